// ==== verilog/irq_priority_command_readback.sv ====
// Command decode, priority rotation, in-service tracking and readback
`timescale 1ns/1ps
module irq_priority_command_readback
(
    input wire logic clk_sys_in, // 25 MHz system clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire irq_cmd_pkg::host_bus_t host_in, // Host port strobes and data
    input wire logic [7:0] pending_request_vector_in, // Latched requests
    input wire logic ack_in, // Acknowledge pulse, one cycle
    input wire logic auto_done_option_in, // Automatic done enabled
    output logic [7:0] data_out, // Read data to host
    output logic data_oe_out, // Read data drive enable
    output logic int_out, // Request to processor
    output logic ack_valid_out, // Acknowledge answer pulse
    output logic [2:0] ack_level_out, // Acknowledged level
    output logic [7:0] clear_request_out, // Request latch clear pulse
    output logic [7:0] in_service_vector_out, // In-service levels
    output logic [7:0] mask_vector_out, // Mask levels
    output logic special_mask_out // Special mask mode active
);
    import irq_cmd_pkg::*;
    // ****************************************
    // State
    // ****************************************
    logic [7:0] in_service_vector_r; // In-service bits
    logic [7:0] mask_vector_r; // Mask bits
    logic [2:0] lowest_r; // Lowest-priority level
    logic rot_auto_r; // Rotate on automatic done
    logic special_mask_r; // Special mask mode
    logic poll_pending_r; // Next even read is poll
    logic read_sel_insvc_r; // Readback selects in-service
    logic rd_d_r; // Read strobe delayed
    logic [7:0] data_r; // Read data register
    logic int_r; // Processor request register
    logic ack_valid_r; // Acknowledge answer
    logic [2:0] ack_level_r; // Acknowledged level
    logic [7:0] clear_req_r; // Request latch clear
    // ****************************************
    // Decode
    // ****************************************
    logic rd_rise; // Read begins this cycle
    logic even_wr; // Write at even port
    logic prio_wr; // Priority command write
    logic rb_cmd_wr; // Mask/read command write
    logic mask_wr; // Mask write
    logic [2:0] cmd; // Priority command code
    logic [2:0] coded_lvl; // Level in low bits
    logic [7:0] unmasked; // Requests not masked
    logic [7:0] eligible_smm; // Special mask candidates
    pick_t insvc_top; // Highest in-service level
    pick_t req_top; // Highest unmasked request
    pick_t smm_top; // Highest special mask candidate
    pick_t cand; // Request that would be serviced
    assign rd_rise = host_in.rd && !rd_d_r;
    assign even_wr = host_in.wr && !host_in.low_address_line;
    assign prio_wr = even_wr && !host_in.data[BIT_KIND] && !host_in.data[BIT_RB_WORD];
    // Bit 4 set marks an init word, which this block leaves alone
    assign rb_cmd_wr = even_wr && !host_in.data[BIT_TOP] && !host_in.data[BIT_KIND] &&
        host_in.data[BIT_RB_WORD];
    assign mask_wr = host_in.wr && host_in.low_address_line;
    assign cmd = host_in.data[CMD_HI:CMD_LO];
    assign coded_lvl = host_in.data[2:0];
    assign unmasked = pending_request_vector_in & ~mask_vector_r;
    assign eligible_smm = unmasked & ~in_service_vector_r;
    // Priority pickers share one rotation pointer
    level_picker #(.WIDTH(LEVELS)) u_insvc_pick
    (
        .vec_in(in_service_vector_r),
        .lowest_in(lowest_r),
        .pick_out(insvc_top)
    );
    level_picker #(.WIDTH(LEVELS)) u_req_pick
    (
        .vec_in(unmasked),
        .lowest_in(lowest_r),
        .pick_out(req_top)
    );
    level_picker #(.WIDTH(LEVELS)) u_smm_pick
    (
        .vec_in(eligible_smm),
        .lowest_in(lowest_r),
        .pick_out(smm_top)
    );
    // ****************************************
    // Service candidate
    // ****************************************
    // Nesting applies unless special mask mode lifts it
    always_comb
    begin
        cand = '0;
        if (special_mask_r)
        begin
            cand = smm_top;
        end
        else if (req_top.found)
        begin
            if (!insvc_top.found || prio_rank(req_top.level, lowest_r) <
                prio_rank(insvc_top.level, lowest_r))
            begin
                cand = req_top;
            end
        end
    end
    // ****************************************
    // In-service vector
    // ****************************************
    logic [7:0] done_clr; // Bits cleared by a done command
    logic [7:0] ack_set; // Bit set by an acknowledge
    // Done commands pick the bit to clear, acknowledge the bit to set
    always_comb
    begin
        done_clr = 8'h00;
        ack_set = 8'h00;
        if (prio_wr)
        begin
            unique case (cmd)
                CMD_DONE, CMD_ROT_DONE:
                    if (insvc_top.found) done_clr[insvc_top.level] = 1'b1;
                CMD_LVL_DONE, CMD_ROT_LVL_DONE: done_clr[coded_lvl] = 1'b1;
                default: done_clr = 8'h00;
            endcase
        end
        if (ack_in && cand.found && !auto_done_option_in)
        begin
            ack_set[cand.level] = 1'b1;
        end
    end
    // Acknowledge sets win over done commands in the same cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            in_service_vector_r <= 8'h00;
        end
        else
        begin
            in_service_vector_r <= (in_service_vector_r & ~done_clr) | ack_set;
        end
    end
    // ****************************************
    // Priority rotation
    // ****************************************
    // Lowest level moves on rotate and set-priority commands
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            lowest_r <= LOWEST_RESET;
            rot_auto_r <= 1'b0;
        end
        else if (prio_wr)
        begin
            unique case (cmd)
                CMD_ROT_CLR: rot_auto_r <= 1'b0;
                CMD_ROT_SET: rot_auto_r <= 1'b1;
                CMD_ROT_DONE: if (insvc_top.found) lowest_r <= insvc_top.level;
                CMD_ROT_LVL_DONE, CMD_SET_PRI: lowest_r <= coded_lvl;
                default: lowest_r <= lowest_r;
            endcase
        end
        else if (ack_in && cand.found && auto_done_option_in && rot_auto_r)
        begin
            lowest_r <= cand.level;
        end
    end
    // ****************************************
    // Mask and special mask
    // ****************************************
    // Mask may change freely, also in special mask mode
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            mask_vector_r <= MASK_RESET;
        end
        else if (mask_wr)
        begin
            mask_vector_r <= host_in.data;
        end
    end
    // Enable bit gates the set value
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            special_mask_r <= 1'b0;
        end
        else if (rb_cmd_wr && host_in.data[BIT_MCE])
        begin
            special_mask_r <= host_in.data[BIT_MSV];
        end
    end
    // ****************************************
    // Readback selection and query
    // ****************************************
    // Query wins over readback; a poll read consumes the query
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            poll_pending_r <= 1'b0;
            read_sel_insvc_r <= READ_SEL_RESET;
        end
        else if (rb_cmd_wr && host_in.data[BIT_QUERY])
        begin
            poll_pending_r <= 1'b1;
        end
        else if (rb_cmd_wr && host_in.data[BIT_RB_EN])
        begin
            poll_pending_r <= 1'b0;
            read_sel_insvc_r <= host_in.data[BIT_RB_INSVC];
        end
        else if (rd_rise && !host_in.low_address_line)
        begin
            poll_pending_r <= 1'b0;
        end
    end
    // ****************************************
    // Read data path
    // ****************************************
    // Data captured at read start, driven while read lasts
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rd_d_r <= 1'b0;
            data_r <= 8'h00;
        end
        else
        begin
            rd_d_r <= host_in.rd;
            if (rd_rise)
            begin
                if (host_in.low_address_line)
                begin
                    data_r <= mask_vector_r;
                end
                else if (poll_pending_r)
                begin
                    data_r <= {cand.found, 4'h0, cand.level};
                end
                else if (read_sel_insvc_r)
                begin
                    data_r <= in_service_vector_r;
                end
                else
                begin
                    data_r <= pending_request_vector_in;
                end
            end
        end
    end
    // ****************************************
    // Acknowledge answer
    // ****************************************
    // Vanished request still answers, as level seven
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            int_r <= 1'b0;
            ack_valid_r <= 1'b0;
            ack_level_r <= 3'h0;
            clear_req_r <= 8'h00;
        end
        else
        begin
            int_r <= cand.found;
            ack_valid_r <= ack_in;
            clear_req_r <= 8'h00;
            if (ack_in)
            begin
                ack_level_r <= cand.found ? cand.level : SPURIOUS_LEVEL;
                if (cand.found)
                begin
                    clear_req_r[cand.level] <= 1'b1;
                end
            end
        end
    end
    assign data_out = data_r;
    assign data_oe_out = rd_d_r;
    assign int_out = int_r;
    assign ack_valid_out = ack_valid_r;
    assign ack_level_out = ack_level_r;
    assign clear_request_out = clear_req_r;
    assign in_service_vector_out = in_service_vector_r;
    assign mask_vector_out = mask_vector_r;
    assign special_mask_out = special_mask_r;
    // ****************************************
    // Checks
    // ****************************************
    sequence s_prio_wr(logic [2:0] c);
        prio_wr && cmd == c && !ack_in;
    endsequence
    sequence s_even_read;
        rd_rise && !host_in.low_address_line;
    endsequence
    a_rot_done_lowest: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_prio_wr(CMD_ROT_DONE) ##0 insvc_top.found |=>
        lowest_r == $past(insvc_top.level) && !in_service_vector_r[$past(insvc_top.level)])
        else $error("rotate done did not clear and rotate");
    a_set_pri_only: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_prio_wr(CMD_SET_PRI) |=>
        lowest_r == $past(coded_lvl) && in_service_vector_r == $past(in_service_vector_r))
        else $error("set priority wrong");
    a_lvl_done_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_prio_wr(CMD_LVL_DONE) |=> !in_service_vector_r[$past(coded_lvl)] && $stable(lowest_r))
        else $error("specific done wrong");
    a_done_top: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_prio_wr(CMD_DONE) ##0 insvc_top.found |=> !in_service_vector_r[$past(insvc_top.level)])
        else $error("non-specific done missed top bit");
    a_mask_mode_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        rb_cmd_wr |=> special_mask_r ==
        ($past(host_in.data[BIT_MCE]) ? $past(host_in.data[BIT_MSV]) : $past(special_mask_r)))
        else $error("special mask mode wrong");
    a_query_wins: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        rb_cmd_wr && host_in.data[BIT_QUERY] |=> poll_pending_r && $stable(read_sel_insvc_r))
        else $error("query did not override readback");
    a_poll_byte: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_even_read ##0 poll_pending_r |=> data_r[POLL_INT_BIT] == $past(cand.found) &&
        data_r[2:0] == $past(cand.level) && !poll_pending_r)
        else $error("poll byte wrong");
    a_mask_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        rd_rise && host_in.low_address_line |=> data_r == $past(mask_vector_r) ##1 data_oe_out)
        else $error("odd read not mask");
    a_spurious_seven: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ack_in && !cand.found |=> ack_valid_out && ack_level_out == SPURIOUS_LEVEL &&
        clear_request_out == 8'h00)
        else $error("vanished request not answered as seven");
    a_spurious_no_insvc: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ack_in && !cand.found && !prio_wr |=> in_service_vector_r == $past(in_service_vector_r))
        else $error("vanished request set in-service");
endmodule : irq_priority_command_readback

// ==== verilog/irq_cmd_pkg.sv ====
// Constants, command codes and carrier types for the interrupt command block
package irq_cmd_pkg;
    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int unsigned LEVELS = 8; // Request levels
    localparam logic [2:0] LOWEST_RESET = 3'h7; // Level 7 lowest after reset
    localparam logic [2:0] SPURIOUS_LEVEL = 3'h7; // Level given for vanished request
    localparam logic [7:0] MASK_RESET = 8'h00; // All levels unmasked at reset
    localparam logic READ_SEL_RESET = 1'b0; // Readback selects pending vector
    // ****************************************
    // Even-address register offset
    // ****************************************
    localparam logic [7:0] MASK_AND_READBACK_COMMAND_OFS = 8'h20; // Even port
    // ****************************************
    // Command word field positions
    // ****************************************
    localparam int unsigned BIT_TOP = 7; // Zero marks the mask/read word
    localparam int unsigned BIT_MCE = 6; // Mask change enable
    localparam int unsigned BIT_MSV = 5; // Mask set value
    localparam int unsigned BIT_KIND = 4; // Set selects an init word
    localparam int unsigned BIT_RB_WORD = 3; // Set selects the mask/read word
    localparam int unsigned BIT_QUERY = 2; // Query command
    localparam int unsigned BIT_RB_EN = 1; // Readback enable
    localparam int unsigned BIT_RB_INSVC = 0; // Readback selects in-service
    localparam int unsigned CMD_HI = 7; // Priority command field top
    localparam int unsigned CMD_LO = 5; // Priority command field bottom
    localparam int unsigned POLL_INT_BIT = 7; // Pending flag in query byte
    // ****************************************
    // Priority termination command codes
    // ****************************************
    localparam logic [2:0] CMD_NOP = 3'h2; // No operation
    localparam logic [2:0] CMD_ROT_CLR = 3'h0; // Clear rotate on auto done
    localparam logic [2:0] CMD_ROT_SET = 3'h4; // Rotate on auto done
    localparam logic [2:0] CMD_DONE = 3'h1; // Non-specific done
    localparam logic [2:0] CMD_LVL_DONE = 3'h3; // Specific done
    localparam logic [2:0] CMD_ROT_DONE = 3'h5; // Rotate on non-specific done
    localparam logic [2:0] CMD_SET_PRI = 3'h6; // Set lowest priority
    localparam logic [2:0] CMD_ROT_LVL_DONE = 3'h7; // Rotate on specific done
    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic rd; // Read strobe, level
        logic wr; // Write strobe, one-cycle pulse
        logic low_address_line; // Port select
        logic [7:0] data; // Write data
    } host_bus_t;
    typedef struct packed {
        logic found; // Any bit set
        logic [2:0] level; // Highest-priority set level
    } pick_t;
    // Priority rank, zero is highest, for a given lowest level
    function automatic logic [2:0] prio_rank(input logic [2:0] lvl, input logic [2:0] low);
        prio_rank = 3'(lvl - low - 3'h1);
    endfunction : prio_rank
endpackage : irq_cmd_pkg

// ==== verilog/level_picker.sv ====
// Finds the highest-priority set bit of a level vector under rotation
`timescale 1ns/1ps
module level_picker
#(
    parameter int unsigned WIDTH = 8
)
(
    input wire logic [WIDTH-1:0] vec_in, // Candidate bits
    input wire logic [2:0] lowest_in, // Current lowest-priority level
    output irq_cmd_pkg::pick_t pick_out // Found flag and level
);
    import irq_cmd_pkg::*;
    // ****************************************
    // Priority walk
    // ****************************************
    // Walk from lowest priority upward so the highest one wins last
    always_comb
    begin
        logic [2:0] idx;
        idx = 3'h0;
        pick_out = '0;
        for (int k = WIDTH; k >= 1; k--)
        begin
            idx = 3'(lowest_in + 3'(k));
            if (vec_in[idx])
            begin
                pick_out.found = 1'b1;
                pick_out.level = idx;
            end
        end
    end
endmodule : level_picker

// ==== testbench/host_port_model.sv ====
// Host processor model driving the byte-wide command and readback port
`timescale 1ns/1ps
module host_port_model
(
    input wire logic clk_sys_in, // System clock
    output irq_cmd_pkg::host_bus_t host_out // Strobes, port select, data
);
    import irq_cmd_pkg::*;
    // ****************************************
    // Bus cycles
    // ****************************************
    // Idle bus at time zero
    initial
    begin
        host_out = '0;
    end
    // One-cycle write pulse; mask bytes go to the odd port only
    task automatic wr(input logic adr, input logic [7:0] dat);
        @(negedge clk_sys_in);
        host_out.wr = 1'b1;
        host_out.low_address_line = adr;
        host_out.data = dat;
        @(negedge clk_sys_in);
        host_out.wr = 1'b0;
        host_out.data = ~dat; // Released lines never show the old byte
    endtask : wr
    // Read strobe held two cycles, then one idle cycle before the next
    task automatic rd(input logic adr);
        @(negedge clk_sys_in);
        host_out.rd = 1'b1;
        host_out.low_address_line = adr;
        repeat (2) @(negedge clk_sys_in);
        host_out.rd = 1'b0;
        @(negedge clk_sys_in);
    endtask : rd
endmodule : host_port_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the command decode and readback block
`timescale 1ns/1ps
module tb_top;
    import irq_cmd_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys_in; // 25 MHz clock
    logic rst_n_in; // Synchronous reset, active low
    host_bus_t host_bus; // Host port
    logic [7:0] pend; // Request latch model
    logic ack_in; // Acknowledge pulse
    logic auto_done; // Automatic done option
    logic [7:0] data_out; // Read data
    logic data_oe_out; // Read drive enable
    logic int_out; // Processor request
    logic ack_valid_out; // Acknowledge answer
    logic [2:0] ack_level_out; // Acknowledged level
    logic [7:0] clear_request_out; // Latch clear pulse
    logic [7:0] insvc_vec; // In-service levels
    logic [7:0] mask_vec; // Mask levels
    logic special_mask_out; // Special mask active
    logic [7:0] rd_q[$]; // Expected read bytes
    logic [2:0] ack_q[$]; // Expected acknowledge levels
    logic oe_seen; // Read enable seen last cycle
    logic [7:0] lfsr_r; // Random source
    int mismatches; // Failed comparisons
    int num_checks; // All comparisons
    // ****************************************
    // Clock, design and host
    // ****************************************
    // Free-running clock
    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    irq_priority_command_readback dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .host_in(host_bus), .pending_request_vector_in(pend), .ack_in(ack_in),
        .auto_done_option_in(auto_done), .data_out(data_out), .data_oe_out(data_oe_out),
        .int_out(int_out), .ack_valid_out(ack_valid_out), .ack_level_out(ack_level_out),
        .clear_request_out(clear_request_out), .in_service_vector_out(insvc_vec),
        .mask_vector_out(mask_vec), .special_mask_out(special_mask_out));
    host_port_model hm (.clk_sys_in(clk_sys_in), .host_out(host_bus));
    // ****************************************
    // Compare helpers
    // ****************************************
    // Byte comparison
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    // Level comparison
    task automatic chk_lvl(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_lvl
    // Verdict and end of run
    task automatic results();
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // Next random byte
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    // ****************************************
    // Drivers noting expectations
    // ****************************************
    // Read with expected byte
    task automatic rd_exp(input logic adr, input logic [7:0] exp);
        rd_q.push_back(exp);
        hm.rd(adr);
    endtask : rd_exp
    // Acknowledge with expected level; request held through it
    task automatic ack_exp(input logic [2:0] lvl);
        @(negedge clk_sys_in);
        ack_in = 1'b1;
        ack_q.push_back(lvl);
        @(negedge clk_sys_in);
        ack_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask : ack_exp
    // Special mask flag after a write has landed
    task automatic chk_sm(input logic e);
        @(negedge clk_sys_in);
        chk_byte({7'h00, special_mask_out}, {7'h00, e});
    endtask : chk_sm
    // ****************************************
    // Monitor and request latch
    // ****************************************
    // Compare results against the oldest notes
    always @(posedge clk_sys_in)
    begin
        #1;
        if (data_oe_out === 1'b1 && !oe_seen)
        begin
            if (rd_q.size() > 0)
                chk_byte(data_out, rd_q.pop_front());
            else
                chk_byte(data_out, 8'hxx);
        end
        oe_seen = (data_oe_out === 1'b1);
        if (ack_valid_out === 1'b1)
        begin
            if (ack_q.size() > 0)
                chk_lvl(ack_level_out, ack_q.pop_front());
            else
                chk_lvl(ack_level_out, 3'hx);
        end
    end
    // Latched request dropped when acknowledged
    always @(negedge clk_sys_in)
    begin
        if (clear_request_out !== 8'h00)
            pend = pend & ~clear_request_out;
    end
    // Watchdog
    initial
    begin
        #(20000 * 40);
        mismatches++;
        results();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        rst_n_in = 1'b0;
        ack_in = 1'b0;
        auto_done = 1'b0;
        pend = 8'h00;
        oe_seen = 1'b0;
        mismatches = 0;
        num_checks = 0;
        repeat (20) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        lfsr_r = lfsr_next(8'h1f);
        pend = lfsr_r;
        rd_exp(1'b0, lfsr_r);
        rd_exp(1'b1, MASK_RESET);
        lfsr_r = lfsr_next(lfsr_r);
        hm.wr(1'b1, lfsr_r);
        rd_exp(1'b1, lfsr_r);
        chk_byte(mask_vec, lfsr_r);
        hm.wr(1'b1, 8'h0b); // Odd port: mask, not a command
        hm.wr(1'b0, 8'h1b); // Init word, ignored here
        rd_exp(1'b0, pend);
        hm.wr(1'b1, 8'h00);
        hm.wr(1'b0, 8'h0b);
        rd_exp(1'b0, 8'h00);
        rd_exp(1'b0, 8'h00);
        // Nested acknowledge, vanished request, plain done
        pend = 8'h28;
        ack_exp(3'h3);
        ack_exp(3'h7);
        chk_byte(pend, 8'h20);
        chk_byte(insvc_vec, 8'h08);
        rd_exp(1'b0, 8'h08);
        hm.wr(1'b0, 8'h20);
        rd_exp(1'b0, 8'h00);
        // Poll, override and retained selection
        hm.wr(1'b0, 8'h0c);
        rd_exp(1'b0, 8'h85);
        rd_exp(1'b0, 8'h00);
        hm.wr(1'b0, 8'h0e);
        rd_exp(1'b0, 8'h85);
        rd_exp(1'b0, 8'h00);
        hm.wr(1'b0, 8'h0a);
        rd_exp(1'b0, 8'h20);
        hm.wr(1'b0, 8'h0b);
        // Rotation commands
        hm.wr(1'b0, 8'hc4);
        pend = 8'h21;
        ack_exp(3'h5);
        hm.wr(1'b0, 8'he5);
        pend = 8'h41;
        ack_exp(3'h6);
        hm.wr(1'b0, 8'ha0);
        pend = 8'h81;
        ack_exp(3'h7);
        rd_exp(1'b0, 8'h80);
        hm.wr(1'b0, 8'h40);
        rd_exp(1'b0, 8'h80);
        hm.wr(1'b0, 8'h67);
        rd_exp(1'b0, 8'h00);
        hm.wr(1'b0, 8'hc7);
        pend = 8'h01;
        ack_exp(3'h0);
        // Special mask mode
        pend = 8'h10;
        ack_exp(3'h7);
        rd_exp(1'b0, 8'h01);
        chk_byte({7'h00, int_out}, 8'h00);
        hm.wr(1'b0, 8'h68);
        chk_sm(1'b1);
        chk_byte({7'h00, int_out}, 8'h01);
        ack_exp(3'h4);
        rd_exp(1'b0, 8'h11);
        hm.wr(1'b0, 8'h48);
        chk_sm(1'b0);
        hm.wr(1'b0, 8'h28);
        chk_sm(1'b0);
        hm.wr(1'b0, 8'h20);
        hm.wr(1'b0, 8'h20);
        rd_exp(1'b0, 8'h00);
        // Rotate on automatic done, then cleared
        auto_done = 1'b1;
        hm.wr(1'b0, 8'h80);
        pend = 8'h04;
        ack_exp(3'h2);
        pend = 8'h09;
        ack_exp(3'h3);
        rd_exp(1'b0, 8'h00);
        hm.wr(1'b0, 8'h00);
        pend = 8'h05;
        ack_exp(3'h0);
        pend = 8'h12;
        ack_exp(3'h4);
        auto_done = 1'b0;
        // Mid-run reset drops a pending poll, special mask and readback choice
        hm.wr(1'b0, 8'h0c);
        hm.wr(1'b0, 8'h68);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk_sm(1'b0);
        rd_exp(1'b0, pend);
        repeat (4) @(negedge clk_sys_in);
        chk_byte(8'(rd_q.size() + ack_q.size()), 8'h00);
        results();
    end
endmodule : tb_top
